// ===== common/irq_ctl_pkg.sv
package irq_ctl_pkg;

  // register port addresses
  localparam logic [7:0] ADDR_TIMER_CONTROL = 8'h88;
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'ha8;
  localparam logic [7:0] ADDR_SECONDARY = 8'ha9;
  localparam logic [7:0] ADDR_IRQ_PRIORITY = 8'hb8;

  // reset values
  localparam logic [7:0] RST_IRQ_ENABLE = 8'h00;
  localparam logic [7:0] RST_IRQ_PRIORITY = 8'h00;
  localparam logic [7:0] RST_SECONDARY = 8'ha0;
  localparam logic [7:0] RST_TIMER_CONTROL = 8'h00;

  // secondary enable / priority fields
  localparam int BIT_RTC_PRIO_HIGH = 6;
  localparam int BIT_SERIAL_IF_PRIO_HIGH = 4;
  localparam int BIT_METER_IRQ_EN = 3;
  localparam int BIT_RTC_IRQ_EN = 2;
  localparam int BIT_SUPPLY_IRQ_EN = 1;
  localparam int BIT_SERIAL_IF_IRQ_EN = 0;
  // unused bits 7 and 5 read back as their reset value, one
  localparam logic [7:0] SECONDARY_WR_MASK = 8'h5f;
  localparam logic [7:0] SECONDARY_RSVD_READ = 8'ha0;

  // primary enable fields
  localparam int BIT_GLOBAL_IRQ_ENABLE = 7;
  localparam int BIT_TEMP_EN = 6;
  localparam int BIT_TIMER2_EN = 5;
  localparam int BIT_UART_EN = 4;
  localparam int BIT_TIMER1_EN = 3;
  localparam int BIT_EXT1_ENABLE = 2;
  localparam int BIT_TIMER0_EN = 1;
  localparam int BIT_EXT0_ENABLE = 0;

  // primary priority fields
  localparam int BIT_METER_PRIO = 7;
  localparam int BIT_TEMP_PRIO = 6;
  localparam int BIT_TIMER2_PRIO = 5;
  localparam int BIT_UART_PRIO = 4;
  localparam int BIT_TIMER1_PRIO = 3;
  localparam int BIT_EXT1_PRIO = 2;
  localparam int BIT_TIMER0_PRIO = 1;
  localparam int BIT_EXT0_PRIO = 0;

  // timer control fields
  localparam int BIT_TIMER1_OVERFLOW_FLAG = 7;
  localparam int BIT_TIMER0_OVERFLOW_FLAG = 5;
  localparam int BIT_EXT1_FLAG = 3;
  localparam int BIT_EXT1_EDGE_SELECT = 2;
  localparam int BIT_EXT0_FLAG = 1;
  localparam int BIT_EXT0_EDGE_SELECT = 0;

  // sources in polling order, index 0 wins among equals
  localparam int NUM_SRC = 12;
  localparam logic [3:0] SRC_SUPPLY = 4'h0;
  localparam logic [3:0] SRC_RTC = 4'h1;
  localparam logic [3:0] SRC_METER = 4'h2;
  localparam logic [3:0] SRC_WATCHDOG = 4'h3;
  localparam logic [3:0] SRC_TEMP = 4'h4;
  localparam logic [3:0] SRC_EXT0 = 4'h5;
  localparam logic [3:0] SRC_TIMER0 = 4'h6;
  localparam logic [3:0] SRC_EXT1 = 4'h7;
  localparam logic [3:0] SRC_TIMER1 = 4'h8;
  localparam logic [3:0] SRC_SERIAL_IF = 4'h9;
  localparam logic [3:0] SRC_UART = 4'ha;
  localparam logic [3:0] SRC_TIMER2 = 4'hb;

  // vector per source, same order as above
  localparam logic [15:0] VECTOR_TABLE [NUM_SRC] = '{
    16'h0043, 16'h0053, 16'h004b, 16'h005b, 16'h0033, 16'h0003,
    16'h000b, 16'h0013, 16'h001b, 16'h003b, 16'h0023, 16'h002b};

  // priority levels
  localparam logic [1:0] LVL_LOW = 2'h0;
  localparam logic [1:0] LVL_HIGH = 2'h1;
  localparam logic [1:0] LVL_SUPPLY = 2'h2;
  localparam int NUM_LVL = 3;

  typedef struct packed {
    logic [7:0] irq_enable;
    logic [7:0] irq_priority;
    logic [7:0] secondary;
    logic [7:0] timer_control;
    logic [1:0] pin_prev;
    logic [1:0] wake_pend;
    logic rtc_latch;
    logic temp_latch;
    logic serial_latch;
    logic [2:0] in_service;
    logic req;
    logic [3:0] src;
    logic [1:0] src_lvl;
    logic [15:0] vector;
    logic [7:0] rd_data;
  } ctl_s;

endpackage : irq_ctl_pkg

// ===== verilog/twelve_source_irq_controller.sv
// Overview of operation
// - secondary register bit 6 sets rtc priority, bit 4 serial priority; one is high.
// - secondary bits 3,2,1,0 enable meter, rtc, supply and serial interrupts.
// - equal-level requests are polled supply, rtc, meter, watchdog, temp, ext0 ... timer2.
// - supply monitor alone occupies a top level above both configurable levels.
// - ext0, timer0, ext1, timer1 flags sit in timer control bits 1, 5, 3, 7.
// - uart vector from tx or rx flag; timer2 vector from overflow or external flag.
// - temperature request has no visible flag; it lives only inside this block.
// - supply and meter flags live in their peripherals; software clears the cause.
// - serial, rtc and watchdog status live in their peripherals, not here.
// - an external wake-up from core-off leaves an external interrupt pending.
// - events during core-off leave the ext0 and ext1 flags untouched.
// - rtc, temp and serial requests are latched, cleared only by vectoring to them.
// - clearing rtc or serial status bits keeps a pending request in place.
// - latched requests wait while disabled and are served once enabled.
// - supply, meter, uart and timer2 flags are not cleared on vectoring.
// - ext flags clear on vectoring only in falling-edge mode.
// - in low-level mode the ext request follows the pin and re-enters.
// - high preempts low, never same level; higher level wins when simultaneous.
// - on grant the core stacks the pc and loads the source vector.
// - primary enable bit 7 gates every source.
//
// Our own choice: the strobed register port.
module twelve_source_irq_controller
  import irq_ctl_pkg::*;
(
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rstn_in,
  // register port
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wr_data_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  output logic [7:0] rd_data_out,
  // peripheral requests, held levels cleared in their own peripherals
  input wire logic supply_monitor_irq_in,
  input wire logic meter_dsp_irq_in,
  input wire logic watchdog_irq_in,
  input wire logic uart_rx_flag_in,
  input wire logic uart_tx_flag_in,
  input wire logic timer2_overflow_flag_in,
  input wire logic timer2_external_flag_in,
  // peripheral one-cycle event pulses
  input wire logic rtc_interval_irq_in,
  input wire logic temp_adc_irq_in,
  input wire logic serial_if_irq_in,
  input wire logic timer0_overflow_in,
  input wire logic timer1_overflow_in,
  // external pins, active low, and wake-up events
  input wire logic ext_irq0_pin_n_in,
  input wire logic ext_irq1_pin_n_in,
  input wire logic ext0_wake_in,
  input wire logic ext1_wake_in,
  input wire logic core_off_mode_in,
  // core handshake
  input wire logic irq_ack_in,
  input wire logic reti_in,
  output logic irq_req_out,
  output logic [15:0] irq_vector_out
);

  ctl_s state_reg;
  ctl_s state_next;

  logic [NUM_SRC-1:0] pend;
  logic [NUM_SRC-1:0] enab;
  logic [NUM_SRC-1:0] prio_hi;
  logic [1:0] pin_n;

  assign pin_n = {ext_irq1_pin_n_in, ext_irq0_pin_n_in};

  // held levels come straight from their peripherals and are cleared there, so this
  // block needs no write path for them
  // pending sources in polling order
  assign pend[SRC_SUPPLY] = supply_monitor_irq_in;
  assign pend[SRC_RTC] = state_reg.rtc_latch;
  assign pend[SRC_METER] = meter_dsp_irq_in;
  assign pend[SRC_WATCHDOG] = watchdog_irq_in;
  assign pend[SRC_TEMP] = state_reg.temp_latch;
  assign pend[SRC_EXT0] = state_reg.timer_control[BIT_EXT0_FLAG] | state_reg.wake_pend[0];
  assign pend[SRC_TIMER0] = state_reg.timer_control[BIT_TIMER0_OVERFLOW_FLAG];
  assign pend[SRC_EXT1] = state_reg.timer_control[BIT_EXT1_FLAG] | state_reg.wake_pend[1];
  assign pend[SRC_TIMER1] = state_reg.timer_control[BIT_TIMER1_OVERFLOW_FLAG];
  assign pend[SRC_SERIAL_IF] = state_reg.serial_latch;
  assign pend[SRC_UART] = uart_rx_flag_in | uart_tx_flag_in;
  assign pend[SRC_TIMER2] = timer2_overflow_flag_in | timer2_external_flag_in;

  // the global enable is applied once, on the final request, not per source
  // individual enables
  assign enab[SRC_SUPPLY] = state_reg.secondary[BIT_SUPPLY_IRQ_EN];
  assign enab[SRC_RTC] = state_reg.secondary[BIT_RTC_IRQ_EN];
  assign enab[SRC_METER] = state_reg.secondary[BIT_METER_IRQ_EN];
  // the watchdog gates its own interrupt in its control register
  assign enab[SRC_WATCHDOG] = 1'b1;
  assign enab[SRC_TEMP] = state_reg.irq_enable[BIT_TEMP_EN];
  assign enab[SRC_EXT0] = state_reg.irq_enable[BIT_EXT0_ENABLE];
  assign enab[SRC_TIMER0] = state_reg.irq_enable[BIT_TIMER0_EN];
  assign enab[SRC_EXT1] = state_reg.irq_enable[BIT_EXT1_ENABLE];
  assign enab[SRC_TIMER1] = state_reg.irq_enable[BIT_TIMER1_EN];
  assign enab[SRC_SERIAL_IF] = state_reg.secondary[BIT_SERIAL_IF_IRQ_EN];
  assign enab[SRC_UART] = state_reg.irq_enable[BIT_UART_EN];
  assign enab[SRC_TIMER2] = state_reg.irq_enable[BIT_TIMER2_EN];

  // configurable priority bits; supply is placed in its own level below
  // the watchdog has no priority bit of its own and always sits in the low level
  assign prio_hi[SRC_SUPPLY] = 1'b0;
  assign prio_hi[SRC_RTC] = state_reg.secondary[BIT_RTC_PRIO_HIGH];
  assign prio_hi[SRC_METER] = state_reg.irq_priority[BIT_METER_PRIO];
  assign prio_hi[SRC_WATCHDOG] = 1'b0;
  assign prio_hi[SRC_TEMP] = state_reg.irq_priority[BIT_TEMP_PRIO];
  assign prio_hi[SRC_EXT0] = state_reg.irq_priority[BIT_EXT0_PRIO];
  assign prio_hi[SRC_TIMER0] = state_reg.irq_priority[BIT_TIMER0_PRIO];
  assign prio_hi[SRC_EXT1] = state_reg.irq_priority[BIT_EXT1_PRIO];
  assign prio_hi[SRC_TIMER1] = state_reg.irq_priority[BIT_TIMER1_PRIO];
  assign prio_hi[SRC_SERIAL_IF] = state_reg.secondary[BIT_SERIAL_IF_PRIO_HIGH];
  assign prio_hi[SRC_UART] = state_reg.irq_priority[BIT_UART_PRIO];
  assign prio_hi[SRC_TIMER2] = state_reg.irq_priority[BIT_TIMER2_PRIO];

  function automatic logic [1:0] level_of(input logic [3:0] idx, input logic hi);
    logic [1:0] lv;
    lv = hi ? LVL_HIGH : LVL_LOW;
    // no register bit can move the supply source out of its own level
    if (idx == SRC_SUPPLY) begin
      lv = LVL_SUPPLY;
    end
    return lv;
  endfunction : level_of

  always_comb begin
    logic found;
    logic [3:0] sel;
    logic [1:0] sel_lvl;
    logic [1:0] lv;
    logic [2:0] busy;
    logic ext_edge;
    logic ext_fall;
    int flag_pos;
    int it_pos;
    state_next = state_reg;
    found = 1'b0;
    sel = SRC_SUPPLY;
    sel_lvl = LVL_LOW;
    lv = LVL_LOW;
    busy = 3'h0;
    ext_edge = 1'b0;
    ext_fall = 1'b0;
    flag_pos = 0;
    it_pos = 0;

    // register writes
    if (wr_en_in) begin
      case (addr_in)
        ADDR_IRQ_ENABLE: state_next.irq_enable = wr_data_in;
        ADDR_IRQ_PRIORITY: state_next.irq_priority = wr_data_in;
        ADDR_SECONDARY: state_next.secondary = wr_data_in & SECONDARY_WR_MASK;
        ADDR_TIMER_CONTROL: state_next.timer_control = wr_data_in;
        default: ;
      endcase
    end

    // return from service: retire the highest level in service
    // the core never raises reti and ack together; if it did, the ack below still
    // marks its level because it is applied after the retire
    if (reti_in) begin
      if (state_reg.in_service[LVL_SUPPLY]) begin
        state_next.in_service[LVL_SUPPLY] = 1'b0;
      end else if (state_reg.in_service[LVL_HIGH]) begin
        state_next.in_service[LVL_HIGH] = 1'b0;
      end else begin
        state_next.in_service[LVL_LOW] = 1'b0;
      end
    end

    // vectoring: the core stacks its pc and jumps to irq_vector_out
    // the level is marked from the registered request, so a better source that
    // arrives in the ack cycle waits for the next evaluation
    if (irq_ack_in && state_reg.req) begin
      state_next.in_service[state_reg.src_lvl] = 1'b1;
      case (state_reg.src)
        SRC_RTC: state_next.rtc_latch = 1'b0;
        SRC_TEMP: state_next.temp_latch = 1'b0;
        SRC_SERIAL_IF: state_next.serial_latch = 1'b0;
        SRC_TIMER0: state_next.timer_control[BIT_TIMER0_OVERFLOW_FLAG] = 1'b0;
        SRC_TIMER1: state_next.timer_control[BIT_TIMER1_OVERFLOW_FLAG] = 1'b0;
        SRC_EXT0: begin
          state_next.wake_pend[0] = 1'b0;
          if (state_reg.timer_control[BIT_EXT0_EDGE_SELECT]) begin
            state_next.timer_control[BIT_EXT0_FLAG] = 1'b0;
          end
        end
        SRC_EXT1: begin
          state_next.wake_pend[1] = 1'b0;
          if (state_reg.timer_control[BIT_EXT1_EDGE_SELECT]) begin
            state_next.timer_control[BIT_EXT1_FLAG] = 1'b0;
          end
        end
        // supply, meter, uart, timer2 and watchdog are cleared at their source
        default: ;
      endcase
    end

    // hardware sets come last so an event beats a same-cycle clear
    for (int k = 0; k < 2; k++) begin
      flag_pos = (k == 0) ? BIT_EXT0_FLAG : BIT_EXT1_FLAG;
      it_pos = (k == 0) ? BIT_EXT0_EDGE_SELECT : BIT_EXT1_EDGE_SELECT;
      ext_edge = state_reg.timer_control[it_pos];
      ext_fall = state_reg.pin_prev[k] & ~pin_n[k];
      // pin history keeps running so no stale edge appears on wake-up
      state_next.pin_prev[k] = pin_n[k];
      // flags freeze while the core is off; an event then reaches the core only
      // through its wake pulse
      if (!core_off_mode_in) begin
        if (ext_edge) begin
          if (ext_fall) begin
            state_next.timer_control[flag_pos] = 1'b1;
          end
        end else begin
          // the pin overwrites the flag every cycle, so a software write to a
          // level-mode flag has no lasting effect
          state_next.timer_control[flag_pos] = ~pin_n[k];
        end
      end
    end
    if (ext0_wake_in) begin
      state_next.wake_pend[0] = 1'b1;
    end
    if (ext1_wake_in) begin
      state_next.wake_pend[1] = 1'b1;
    end
    if (timer0_overflow_in) begin
      state_next.timer_control[BIT_TIMER0_OVERFLOW_FLAG] = 1'b1;
    end
    if (timer1_overflow_in) begin
      state_next.timer_control[BIT_TIMER1_OVERFLOW_FLAG] = 1'b1;
    end
    // latches ignore status clears in the peripherals
    if (rtc_interval_irq_in) begin
      state_next.rtc_latch = 1'b1;
    end
    if (temp_adc_irq_in) begin
      state_next.temp_latch = 1'b1;
    end
    if (serial_if_irq_in) begin
      state_next.serial_latch = 1'b1;
    end

    // arbitration: later hits override, so the loops end on the highest level
    // and, within it, the first source in polling order
    // a level is blocked while it or any level above it is in service
    busy = state_reg.in_service;
    for (int l = 0; l < NUM_LVL; l++) begin
      for (int i = NUM_SRC - 1; i >= 0; i--) begin
        lv = level_of(i[3:0], prio_hi[i]);
        // latched requests simply wait here until enabled
        if (pend[i] && enab[i] && lv == l[1:0] && (busy >> l) == 3'h0) begin
          found = 1'b1;
          sel = i[3:0];
          sel_lvl = lv;
        end
      end
    end

    // a granted request is dropped in its ack cycle and re-evaluated after
    // the drop keeps the core from taking the same vector again before the
    // clears of the ack cycle have landed
    state_next.req = found && state_reg.irq_enable[BIT_GLOBAL_IRQ_ENABLE] &&
                     !(irq_ack_in && state_reg.req);
    state_next.src = sel;
    state_next.src_lvl = sel_lvl;
    state_next.vector = VECTOR_TABLE[sel];

    // read data stand for exactly one cycle
    // unmapped addresses read as zero and writes to them are dropped
    state_next.rd_data = 8'h00;
    if (rd_en_in) begin
      case (addr_in)
        ADDR_IRQ_ENABLE: state_next.rd_data = state_reg.irq_enable;
        ADDR_IRQ_PRIORITY: state_next.rd_data = state_reg.irq_priority;
        ADDR_SECONDARY: state_next.rd_data = state_reg.secondary | SECONDARY_RSVD_READ;
        ADDR_TIMER_CONTROL: state_next.rd_data = state_reg.timer_control;
        default: state_next.rd_data = 8'h00;
      endcase
    end
  end

  // synchronous reset; the pin history starts at the idle high level so the
  // first cycle after reset shows no false falling edge
  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      state_reg <= '0;
      state_reg.irq_enable <= RST_IRQ_ENABLE;
      state_reg.irq_priority <= RST_IRQ_PRIORITY;
      state_reg.secondary <= RST_SECONDARY & SECONDARY_WR_MASK;
      state_reg.timer_control <= RST_TIMER_CONTROL;
      state_reg.pin_prev <= 2'h3;
    end else begin
      state_reg <= state_next;
    end
  end

  assign rd_data_out = state_reg.rd_data;
  assign irq_req_out = state_reg.req;
  assign irq_vector_out = state_reg.vector;

endmodule : twelve_source_irq_controller

// ===== verification/twelve_source_irq_controller_properties.sv
module irq_ctl_checker
  import irq_ctl_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rstn_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wr_data_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  input wire logic [7:0] rd_data_out,
  input wire logic irq_ack_in,
  input wire logic irq_req_out,
  input wire logic [15:0] irq_vector_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rstn_in);
  logic global_en_reg;
  wire logic mapped = addr_in == ADDR_TIMER_CONTROL || addr_in == ADDR_IRQ_ENABLE ||
    addr_in == ADDR_SECONDARY || addr_in == ADDR_IRQ_PRIORITY;
  // shadow of the global enable, as software last wrote it
  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) global_en_reg <= 1'b0;
    else if (wr_en_in && addr_in == ADDR_IRQ_ENABLE) global_en_reg <= wr_data_in[7];
  end
  rd_idle_zero_a: assert property (!rd_en_in |=> rd_data_out == 8'h00)
    else $error("read data not zero outside read cycle");
  unmapped_read_a: assert property (rd_en_in && !mapped |=> rd_data_out == 8'h00)
    else $error("unmapped read returned data");
  secondary_rsvd_a: assert property (rd_en_in && addr_in == ADDR_SECONDARY
    |=> rd_data_out[7] && rd_data_out[5])
    else $error("secondary unused bits not one");
  secondary_rdback_a: assert property (wr_en_in && addr_in == ADDR_SECONDARY ##1
    rd_en_in && addr_in == ADDR_SECONDARY
    |=> rd_data_out == (($past(wr_data_in, 2) & 8'h5f) | 8'ha0))
    else $error("secondary readback mismatch");
  enable_rdback_a: assert property (wr_en_in && addr_in == ADDR_IRQ_ENABLE ##1
    rd_en_in && addr_in == ADDR_IRQ_ENABLE |=> rd_data_out == $past(wr_data_in, 2))
    else $error("enable readback mismatch");
  ack_drop_a: assert property (irq_ack_in && irq_req_out |=> !irq_req_out)
    else $error("request stayed up after ack");
  global_off_a: assert property (!global_en_reg && !$past(global_en_reg)
    |-> !irq_req_out)
    else $error("request while globally disabled");
  vector_slot_a: assert property (irq_req_out
    |-> irq_vector_out[2:0] == 3'h3 && irq_vector_out <= 16'h005b)
    else $error("vector outside table");
endmodule : irq_ctl_checker

bind twelve_source_irq_controller irq_ctl_checker i_checker (.core_clk_in, .rstn_in, .addr_in,
  .wr_data_in, .wr_en_in, .rd_en_in, .rd_data_out, .irq_ack_in, .irq_req_out, .irq_vector_out);

// ===== verification/core_ack_model.sv
module core_ack_model (
  input wire logic core_clk_in,
  input wire logic rstn_in,
  input wire logic irq_req_in,
  input wire logic [15:0] irq_vector_in,
  input wire logic [3:0] ack_delay_in,
  output logic irq_ack_out,
  output logic [15:0] taken_vector_out,
  output logic [7:0] ack_cnt_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] wait_cnt;
  // a withdrawn request leaves the ack unanswered, as on the real core
  always @(posedge core_clk_in) begin
    if (!rstn_in) begin
      irq_ack_out <= 1'b0;
      wait_cnt <= 4'h0;
      taken_vector_out <= 16'h0000;
      ack_cnt_out <= 8'h00;
    end else if (irq_ack_out) begin
      irq_ack_out <= 1'b0;
      wait_cnt <= 4'h0;
      if (irq_req_in) begin
        taken_vector_out <= irq_vector_in;
        ack_cnt_out <= ack_cnt_out + 8'h01;
      end
    end else if (irq_req_in && wait_cnt >= ack_delay_in) irq_ack_out <= 1'b1;
    else if (irq_req_in) wait_cnt <= wait_cnt + 4'h1;
    else wait_cnt <= 4'h0;
  end
endmodule : core_ack_model

// ===== verification/twelve_source_irq_controller_tb.sv
module twelve_source_irq_controller_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk, rstn, wr_en, rd_en, supply, core_off, pin0_n, pin1_n, wake0, reti, ack, req;
  logic [7:0] addr, wr_data, rd_data, ack_cnt;
  logic [4:0] evt;
  logic [5:0] held;
  logic [15:0] vec, taken;
  logic [3:0] delay;
  int error_cnt = 0;
  int compares = 0;
  logic [15:0] poll_tab [5] = '{16'h0053, 16'h0033, 16'h000b, 16'h001b, 16'h003b};
  logic [15:0] held_tab [6] = '{16'h0023, 16'h0023, 16'h002b, 16'h002b, 16'h005b, 16'h004b};
  logic [7:0] map_a [5] = '{8'h88, 8'ha8, 8'ha9, 8'hb8, 8'h55};
  logic [7:0] map_d [5] = '{8'h00, 8'h00, 8'ha0, 8'h00, 8'h00};

  twelve_source_irq_controller i_dut (.core_clk_in(core_clk), .rstn_in(rstn), .addr_in(addr),
    .wr_data_in(wr_data), .wr_en_in(wr_en), .rd_en_in(rd_en), .rd_data_out(rd_data),
    .supply_monitor_irq_in(supply), .meter_dsp_irq_in(held[5]), .watchdog_irq_in(held[4]),
    .uart_rx_flag_in(held[0]), .uart_tx_flag_in(held[1]), .timer2_overflow_flag_in(held[2]),
    .timer2_external_flag_in(held[3]), .rtc_interval_irq_in(evt[4]), .temp_adc_irq_in(evt[3]),
    .serial_if_irq_in(evt[2]), .timer0_overflow_in(evt[1]), .timer1_overflow_in(evt[0]),
    .ext_irq0_pin_n_in(pin0_n), .ext_irq1_pin_n_in(pin1_n), .ext0_wake_in(wake0),
    .ext1_wake_in(1'b0), .core_off_mode_in(core_off), .irq_ack_in(ack), .reti_in(reti),
    .irq_req_out(req), .irq_vector_out(vec));
  core_ack_model i_core (.core_clk_in(core_clk), .rstn_in(rstn), .irq_req_in(req),
    .irq_vector_in(vec), .ack_delay_in(delay), .irq_ack_out(ack), .taken_vector_out(taken),
    .ack_cnt_out(ack_cnt));

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge core_clk);
    wr_en <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge core_clk);
    rd_en <= 1'b0;
    #1 check("rd_data", {8'h00, rd_data}, {8'h00, exp});
  endtask : rd

  task automatic pulse(input logic [4:0] m);
    @(posedge core_clk);
    evt <= m;
    @(posedge core_clk);
    evt <= 5'h00;
  endtask : pulse

  task automatic do_reti();
    @(posedge core_clk);
    reti <= 1'b1;
    @(posedge core_clk);
    reti <= 1'b0;
  endtask : do_reti

  // bounded wait for the core to take a vector
  task automatic expect_ack(input logic [15:0] exp);
    logic [7:0] c0;
    int n;
    c0 = ack_cnt;
    n = 0;
    while (ack_cnt === c0 && n < 60) begin
      @(posedge core_clk);
      #1 n++;
    end
    check("ack count", {8'h00, ack_cnt}, {8'h00, c0 + 8'h01});
    check("taken vector", taken, exp);
  endtask : expect_ack

  task automatic no_ack(input int cycles);
    logic [7:0] c0;
    c0 = ack_cnt;
    repeat (cycles) @(posedge core_clk);
    #1 check("ack count", {8'h00, ack_cnt}, {8'h00, c0});
  endtask : no_ack

  task automatic wrap_up();
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up

  initial begin
    repeat (20000) @(posedge core_clk);
    error_cnt++;
    wrap_up();
  end

  initial begin
    {rstn, wr_en, rd_en, supply, core_off, wake0, reti} = 7'h00;
    {addr, wr_data, evt, held} = '0;
    pin0_n = 1'b1;
    pin1_n = 1'b1;
    delay = 4'h0;
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    for (int i = 0; i < 5; i++) rd(map_a[i], map_d[i]);
    wr(8'ha9, 8'h50);
    rd(8'ha9, 8'hf0);
    wr(8'h55, 8'hff);
    rd(8'h55, 8'h00);
    wr(8'ha8, 8'h82);
    rd(8'ha8, 8'h82);
    pulse(5'h02);
    expect_ack(16'h000b);
    rd(8'h88, 8'h00);
    do_reti();
    // slow core so all latched sources are pending together
    delay = 4'h3;
    wr(8'ha8, 8'hca);
    wr(8'ha9, 8'h05);
    pulse(5'h1f);
    for (int i = 0; i < 5; i++) begin
      expect_ack(poll_tab[i]);
      do_reti();
    end
    delay = 4'h0;
    wr(8'ha9, 8'h00);
    pulse(5'h04);
    no_ack(10);
    wr(8'ha9, 8'h01);
    expect_ack(16'h003b);
    do_reti();
    wr(8'ha8, 8'hb0);
    wr(8'ha9, 8'h08);
    for (int i = 0; i < 6; i++) begin
      held <= 6'h01 << i;
      expect_ack(held_tab[i]);
      do_reti();
      expect_ack(held_tab[i]);
      held <= 6'h00;
      do_reti();
    end
    wr(8'ha8, 8'h8a);
    wr(8'ha9, 8'h02);
    pulse(5'h02);
    expect_ack(16'h000b);
    pulse(5'h01);
    no_ack(10);
    supply <= 1'b1;
    expect_ack(16'h0043);
    supply <= 1'b0;
    do_reti();
    no_ack(6);
    do_reti();
    expect_ack(16'h001b);
    do_reti();
    wr(8'ha9, 8'h44);
    pulse(5'h02);
    expect_ack(16'h000b);
    pulse(5'h10);
    expect_ack(16'h0053);
    do_reti();
    do_reti();
    wr(8'h88, 8'h00);
    wr(8'ha8, 8'h81);
    pin0_n <= 1'b0;
    expect_ack(16'h0003);
    do_reti();
    expect_ack(16'h0003);
    pin0_n <= 1'b1;
    do_reti();
    no_ack(8);
    wr(8'h88, 8'h01);
    pin0_n <= 1'b0;
    expect_ack(16'h0003);
    rd(8'h88, 8'h01);
    pin0_n <= 1'b1;
    do_reti();
    no_ack(8);
    wr(8'h88, 8'h05);
    wr(8'ha8, 8'h84);
    pin1_n <= 1'b0;
    expect_ack(16'h0013);
    rd(8'h88, 8'h05);
    pin1_n <= 1'b1;
    do_reti();
    wr(8'ha8, 8'h01);
    core_off <= 1'b1;
    pin0_n <= 1'b0;
    repeat (3) @(posedge core_clk);
    pin0_n <= 1'b1;
    wake0 <= 1'b1;
    @(posedge core_clk);
    wake0 <= 1'b0;
    rd(8'h88, 8'h05);
    core_off <= 1'b0;
    no_ack(6);
    wr(8'ha8, 8'h81);
    expect_ack(16'h0003);
    do_reti();
    wrap_up();
  end
endmodule : twelve_source_irq_controller_tb
